// >>> src/wdms_map.svh
// Timing constants for the watchdog and manual-reset supervisor.
// Assumes a 10 MHz reference clock; included by the top module.
`ifndef WDMS_MAP_SVH
`define WDMS_MAP_SVH
`define WDMS_CLK_PERIOD_NS      100
`define WDMS_MR_GLITCH_NS       100
`define WDMS_MR_FILT_CYC        (((`WDMS_MR_GLITCH_NS + `WDMS_CLK_PERIOD_NS - 1) / `WDMS_CLK_PERIOD_NS) + 1)
`define WDMS_SVC_PULSE_NS       50
`define WDMS_DEADLINE_CYC       16000000
`define WDMS_HOLD_CYC           1400000
`define WDMS_SAG_US             4
`define WDMS_SAG_CYC            ((`WDMS_SAG_US * 1000) / `WDMS_CLK_PERIOD_NS)
`define WDMS_FLOAT_NUM          7
`define WDMS_FLOAT_DEN          8
`endif

// >>> src/wdms_pkg.sv
// Types for the watchdog and manual-reset supervisor.
// Assumes nothing beyond the map header.
package wdms_pkg;
   typedef enum logic [1:0] {
      WDMS_RUN  = 2'b00,
      WDMS_HOLD = 2'b01,
      WDMS_WAIT = 2'b10
   } wdms_state_t;
endpackage : wdms_pkg

// >>> src/wdms_top.sv
// Watchdog and manual-reset supervisor driving a processor reset line.
// Assumes pins arrive asynchronously and supply/float sensing comes from analog helpers.
//
// What this block does
// - Reset stays asserted while the manual reset input is low.
// - After manual reset releases, reset holds for the full post-release time.
// - Manual reset lows of about 100 ns are filtered out.
// - No service edge within the deadline asserts reset.
// - Any service edge stable for two samples, or reset assertion, clears the watchdog; a 50 ns pulse is missed.
// - Watchdog timer stays at zero while reset is asserted.
// - On reset release the watchdog counts from zero.
// - A floating service input is cleared internally every 7/8 deadline.
// - Open-drain reset pin is pulled low only while reset is asserted.
// - Supply dips shorter than about 4 us cause no reset.
// - Any reset cause holds reset for the post-release time, then restarts watchdog.
`timescale 1ns/1ps
`include "wdms_map.svh"
module wdms_top
   import wdms_pkg::*;
#(
   parameter int DEADLINE_CYC = `WDMS_DEADLINE_CYC,
   parameter int HOLD_CYC     = `WDMS_HOLD_CYC
) (
   // Clock and reset.
   input  wire logic I_REF_CLK,
   input  wire logic I_SRST,
   // Supervised pins.
   input  wire logic I_MANUAL_RESET_N_INPUT,
   input  wire logic I_WATCHDOG_SERVICE_INPUT,
   input  wire logic I_SERVICE_FLOATING,
   input  wire logic I_SUPPLY_LOW,
   // Reset outputs.
   output logic      O_RESET,
   output logic      O_RESET_N,
   output logic      O_RESET_N_OE
);
   import wdms_pkg::*;

   localparam int FILT_CYC  = `WDMS_MR_FILT_CYC;
   localparam int SAG_CYC   = `WDMS_SAG_CYC;
   localparam int FLOAT_CYC = (DEADLINE_CYC / `WDMS_FLOAT_DEN) * `WDMS_FLOAT_NUM;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   // Three stages; a change counts once stages two and three agree, except the float flag, which is taken from stage three alone.
   logic [2:0] mr_s_q, wdi_s_q, flt_s_q, sup_s_q;
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         mr_s_q  <= 3'h7;
         wdi_s_q <= 3'h0;
         flt_s_q <= 3'h0;
         sup_s_q <= 3'h0;
      end else begin
         mr_s_q  <= {mr_s_q[1:0], I_MANUAL_RESET_N_INPUT};
         wdi_s_q <= {wdi_s_q[1:0], I_WATCHDOG_SERVICE_INPUT};
         flt_s_q <= {flt_s_q[1:0], I_SERVICE_FLOATING};
         sup_s_q <= {sup_s_q[1:0], I_SUPPLY_LOW};
      end
   end

   // Stable level tracker for the service pin; edge fires when the agreed level changes.
   logic wdi_lvl_q;
   logic wdi_edge;
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         wdi_lvl_q <= 1'b0;
      end else if (wdi_s_q[2] == wdi_s_q[1]) begin
         wdi_lvl_q <= wdi_s_q[2];
      end
   end
   // At 100 ns sampling a 50 ns pulse never reaches two agreeing stages and is always missed; a faster reference clock closes that gap.
   assign wdi_edge = (wdi_s_q[2] == wdi_s_q[1]) && (wdi_s_q[2] != wdi_lvl_q);

   // ==========================================================
   // Manual reset glitch filter
   // ==========================================================
   logic [7:0] mr_cnt_q;
   logic       mr_low_q;
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         mr_cnt_q <= 8'h00;
         mr_low_q <= 1'b0;
      end else if (mr_s_q[2] == mr_s_q[1] && !mr_s_q[2]) begin
         if (mr_cnt_q >= 8'(FILT_CYC)) begin
            mr_low_q <= 1'b1;
         end else begin
            mr_cnt_q <= mr_cnt_q + 8'h01;
         end
      end else if (mr_s_q[2] == mr_s_q[1]) begin
         mr_cnt_q <= 8'h00;
         mr_low_q <= 1'b0;
      end
   end

   // ==========================================================
   // Supply dip filter
   // ==========================================================
   logic [7:0] sag_cnt_q;
   logic       sag_q;
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         sag_cnt_q <= 8'h00;
         sag_q     <= 1'b0;
      end else if (sup_s_q[2] == sup_s_q[1] && sup_s_q[2]) begin
         if (sag_cnt_q >= 8'(SAG_CYC)) begin
            sag_q <= 1'b1;
         end else begin
            sag_cnt_q <= sag_cnt_q + 8'h01;
         end
      end else if (sup_s_q[2] == sup_s_q[1]) begin
         sag_cnt_q <= 8'h00;
         sag_q     <= 1'b0;
      end
   end

   // ==========================================================
   // Watchdog timer
   // ==========================================================
   logic [31:0] wd_cnt_q;
   logic        wd_expire;
   logic        in_reset;
   logic        float_clr;
   assign float_clr = flt_s_q[2] && (wd_cnt_q >= 32'(FLOAT_CYC - 1));
   assign wd_expire = !in_reset && !float_clr && !wdi_edge && (wd_cnt_q >= 32'(DEADLINE_CYC - 1));
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST || in_reset || wdi_edge || float_clr) begin
         wd_cnt_q <= 32'h0;
      end else begin
         wd_cnt_q <= wd_cnt_q + 32'h1;
      end
   end

   // ==========================================================
   // Reset sequencer
   // ==========================================================
   wdms_state_t st_q;
   logic [31:0] hold_q;
   logic        cause;
   assign cause    = mr_low_q || sag_q;
   assign in_reset = (st_q != WDMS_RUN);
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         st_q   <= WDMS_HOLD;
         hold_q <= 32'h0;
      end else begin
         case (st_q)
            WDMS_RUN: begin
               if (cause) begin
                  st_q <= WDMS_WAIT;
               end else if (wd_expire) begin
                  st_q   <= WDMS_HOLD;
                  hold_q <= 32'h0;
               end
            end
            WDMS_WAIT: begin
               hold_q <= 32'h0;
               if (!cause) begin
                  st_q <= WDMS_HOLD;
               end
            end
            WDMS_HOLD: begin
               if (cause) begin
                  st_q <= WDMS_WAIT;
               end else if (hold_q >= 32'(HOLD_CYC - 1)) begin
                  st_q <= WDMS_RUN;
               end else begin
                  hold_q <= hold_q + 32'h1;
               end
            end
            default: begin
               st_q <= WDMS_HOLD;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Open-drain style: the pin is driven low only while reset is asserted.
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         O_RESET      <= 1'b1;
         O_RESET_N    <= 1'b0;
         O_RESET_N_OE <= 1'b1;
      end else begin
         O_RESET      <= in_reset;
         O_RESET_N    <= 1'b0;
         O_RESET_N_OE <= in_reset;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   a_wd_zero_in_reset: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      in_reset |=> (wd_cnt_q == 32'h0)) else $error("watchdog count not zero in reset");
   a_mr_holds_reset: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      mr_low_q |-> ##2 O_RESET) else $error("reset not asserted for manual reset");
   a_expire_resets: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      wd_expire |=> ##1 O_RESET) else $error("watchdog expiry did not reset");
   a_oe_follows: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      (O_RESET_N_OE == $past(in_reset)) && !O_RESET_N && (O_RESET == O_RESET_N_OE))
      else $error("pin enable disagrees with reset");
   a_hold_min: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      (st_q == WDMS_HOLD && hold_q == 32'h0) |-> in_reset [*2]) else $error("hold ended early");
   a_hold_entry: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      (st_q != WDMS_HOLD) ##1 (st_q == WDMS_HOLD) |-> (hold_q == 32'h0))
      else $error("hold count not restarted");
   a_hold_full: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      $fell(in_reset) |-> ($past(st_q) == WDMS_HOLD) && ($past(hold_q) == 32'(HOLD_CYC - 1)))
      else $error("hold ended before full count");
   a_edge_clears: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      wdi_edge |=> (wd_cnt_q == 32'h0)) else $error("service edge did not clear");
   a_release_zero: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      $fell(in_reset) |-> (wd_cnt_q == 32'h0)) else $error("watchdog not zero at release");
   a_float_no_exp: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      flt_s_q[2] |-> !wd_expire) else $error("floating service expired");
   a_glitch_reject: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      $rose(mr_low_q) |-> $past(mr_cnt_q) >= 8'(FILT_CYC)) else $error("manual glitch accepted");
   a_sag_reject: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
      $rose(sag_q) |-> $past(sag_cnt_q) >= 8'(SAG_CYC)) else $error("short sag accepted");
endmodule : wdms_top

// >>> sim/wdms_cpu_model.sv
// Processor model that services the supervisor's watchdog pin.
// Assumes the bench clock; it drives only the service pin.
`timescale 1ns/1ps
module wdms_cpu_model (
   // Clock and control.
   input  wire logic       i_clk,
   input  wire logic       i_en,
   input  wire logic       i_in_reset,
   input  wire logic [7:0] i_gap,
   // Service pin.
   output logic            o_service
);
   int cnt = 0;
   initial o_service = 1'b0;
   // The level is toggled at one point with separate thresholds; it rests low and stays high only briefly.
   always @(negedge i_clk) begin
      if (i_en && !i_in_reset && cnt >= (o_service ? 2 : i_gap)) begin
         o_service <= ~o_service;
         cnt       <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : wdms_cpu_model

// >>> sim/tb_top.sv
// Self-checking bench for the watchdog and manual-reset supervisor.
// Assumes short counts of 200 and 50 cycles so that every timeout fits in the run.
`timescale 1ns/1ps
module tb_top;
   localparam int DL = 200;
   localparam int HD = 50;
   logic        I_REF_CLK = 1'b0;
   logic        I_SRST = 1'b1;
   logic        mr_n = 1'b1;
   logic        flt = 1'b0;
   logic        sup = 1'b0;
   logic        svc_en = 1'b0;
   logic [7:0]  gap = 8'h10;
   logic        svc;
   logic        rst;
   logic        rst_n;
   logic        rst_oe;
   int          fail_count = 0;
   int          checks_done = 0;
   logic [31:0] lfsr = 32'hCA55D393;

   initial forever #50 I_REF_CLK = ~I_REF_CLK;

   wdms_top #(.DEADLINE_CYC(DL), .HOLD_CYC(HD)) u_wdms_top (.I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST),
      .I_MANUAL_RESET_N_INPUT(mr_n), .I_WATCHDOG_SERVICE_INPUT(svc), .I_SERVICE_FLOATING(flt),
      .I_SUPPLY_LOW(sup), .O_RESET(rst), .O_RESET_N(rst_n), .O_RESET_N_OE(rst_oe));
   wdms_cpu_model u_wdms_cpu_model (.i_clk(I_REF_CLK), .i_en(svc_en), .i_in_reset(rst), .i_gap(gap),
      .o_service(svc));

   // ==========================================
   // Helpers
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   // A hold is long enough once it covers the whole post-release count.
   function automatic logic hold_ok(input int took);
      return took >= HD;
   endfunction : hold_ok
   task automatic check(input string what, input logic exp, input logic seen);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %b seen %b", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge I_REF_CLK);
   endtask : cyc
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   // Bounded wait for the reset output to reach a level; a lapsed bound ends the run.
   task automatic wait_rst(input logic lvl, input int bound, output int took);
      took = 0;
      while (rst !== lvl && took < bound) begin
         cyc(1);
         took++;
      end
      if (rst !== lvl) begin
         fail_count++;
         $display("unexpected reset level: expected %b seen %b", lvl, rst);
         results();
      end
   endtask : wait_rst

   // ==========================================
   // Sequence
   initial begin
      int took;
      cyc(4);
      I_SRST = 1'b0;
      cyc(1);
      check("pin pulled low", 1'b1, rst_oe & ~rst_n);
      wait_rst(1'b0, HD + 20, took);
      check("hold after start", 1'b1, hold_ok(took));
      check("pin released", 1'b0, rst_oe);
      $display("test start done");
      mr_n = 1'b0;
      cyc(10);
      check("manual reset", 1'b1, rst);
      cyc(300);
      check("manual held", 1'b1, rst);
      mr_n = 1'b1;
      wait_rst(1'b0, HD + 20, took);
      check("manual hold", 1'b1, hold_ok(took));
      wait_rst(1'b1, DL + 20, took);
      check("deadline from zero", 1'b1, took >= DL - 10);
      wait_rst(1'b0, HD + 20, took);
      check("watchdog hold", 1'b1, hold_ok(took));
      $display("test manual and deadline done");
      svc_en = 1'b1;
      for (int i = 0; i < 10; i++) begin
         lfsr = next_rand(lfsr);
         gap = (i == 0) ? 8'h02 : {1'b0, lfsr[6:0]} + 8'h02;
         repeat (150) begin
            cyc(1);
            check("serviced", 1'b0, rst);
         end
      end
      mr_n = 1'b0;
      cyc(1);
      mr_n = 1'b1;
      sup = 1'b1;
      cyc(20);
      sup = 1'b0;
      cyc(15);
      check("glitches ignored", 1'b0, rst);
      sup = 1'b1;
      wait_rst(1'b1, 60, took);
      check("sag length", 1'b1, took >= 40);
      sup = 1'b0;
      wait_rst(1'b0, HD + 20, took);
      check("supply hold", 1'b1, hold_ok(took));
      $display("test service and glitches done");
      svc_en = 1'b0;
      flt = 1'b1;
      repeat (5 * DL) begin
         cyc(1);
         check("floating service", 1'b0, rst);
      end
      flt = 1'b0;
      wait_rst(1'b1, DL + 20, took);
      check("deadline after float", 1'b1, rst);
      $display("test floating done");
      // A manual reset inside a running hold must restart the full hold on release.
      cyc(10);
      mr_n = 1'b0;
      cyc(30);
      check("manual in hold", 1'b1, rst);
      mr_n = 1'b1;
      wait_rst(1'b0, HD + 20, took);
      check("hold restarted", 1'b1, hold_ok(took));
      $display("test manual in hold done");
      results();
   end
endmodule : tb_top
